/* shared/dsh_pkg.sv */
// constants and types shared by both ends of the debug serial handshake link
// ----------------------------------------------------------------------------
// Functional notes
// - handshake-on/off commands switch acknowledge on/off
// - handshake-on command acknowledges itself
// - reset leaves acknowledge disabled
// - read acknowledged after bus cycle completes
// - write acknowledged after data and bus cycle
// - halt acknowledged on entry to background
// - resume acknowledged on exit from background
// - resume-until-halt acknowledged on next background entry
// - single-step acknowledged on background re-entry
// - resume-with-tags never acknowledged
// - speed probe cancels any pending acknowledge
// - host probe: long low, speedup, release, listen
// - probe detected: discard partial command, await high
// - after high, wait 16, drive low 128
// - then one-cycle high speedup, then release
// - host times reply low to find rate
// - after reply, next fall starts new frame
// - probe during pending acknowledge aborts and replies
// - handshake off: host waits worst-case delay
// - single-step runs one instruction, forces background
// - pending interrupt: step only stacks interrupt
// - acknowledge is 16 low plus speedup high
// - acknowledge no sooner than 32 cycles after command
// ----------------------------------------------------------------------------
package dsh_pkg;

   // device timing, in serial clock cycles
   localparam logic [7:0] DSH_ACK_LOW_CYC     = 8'h10;
   localparam logic [7:0] DSH_ACK_GAP_CYC     = 8'h20;
   localparam logic [7:0] DSH_SYNC_DETECT_CYC = 8'h80;
   localparam logic [7:0] DSH_SYNC_DELAY_CYC  = 8'h10;
   localparam logic [7:0] DSH_SYNC_LOW_CYC    = 8'h80;

   // host timing: probe sized for a serial clock at half the fastest rate
   localparam logic [9:0]  DSH_HOST_REQ_LOW_CYC = 10'h100;
   localparam logic [9:0]  DSH_HOST_ACK_MIN_CYC = 10'h008;
   localparam logic [9:0]  DSH_HOST_ACK_MAX_CYC = 10'h040;
   localparam logic [15:0] DSH_HOST_WORST_CYC   = 16'h0400;

   // commands handed to the device end by the serial front end
   typedef enum logic [3:0] {
      DSH_CMD_ACK_ON       = 4'h0,
      DSH_CMD_ACK_OFF      = 4'h1,
      DSH_CMD_READ         = 4'h2,
      DSH_CMD_WRITE        = 4'h3,
      DSH_CMD_HALT         = 4'h4,
      DSH_CMD_RESUME       = 4'h5,
      DSH_CMD_RESUME_UNTIL = 4'h6,
      DSH_CMD_STEP         = 4'h7,
      DSH_CMD_RESUME_TAGS  = 4'h8,
      DSH_CMD_OTHER        = 4'hF
   } dsh_cmd_type;

   // event that releases a pending acknowledge
   typedef enum logic [1:0] {
      DSH_WAIT_BUS   = 2'h0,
      DSH_WAIT_ENTER = 2'h1,
      DSH_WAIT_EXIT  = 2'h2,
      DSH_WAIT_NOW   = 2'h3
   } dsh_wait_type;

   // device pin sequencer, gray along the usual path
   typedef enum logic [2:0] {
      DSH_DEV_IDLE      = 3'h0,
      DSH_DEV_ACK_LOW   = 3'h1,
      DSH_DEV_ACK_HIGH  = 3'h3,
      DSH_DEV_SYNC_WAIT = 3'h2,
      DSH_DEV_SYNC_DLY  = 3'h6,
      DSH_DEV_SYNC_LOW  = 3'h7,
      DSH_DEV_SYNC_HIGH = 3'h5
   } dsh_dev_state_type;

   // host probe sequencer
   typedef enum logic [2:0] {
      DSH_HOST_IDLE    = 3'h0,
      DSH_HOST_REQ_LOW = 3'h1,
      DSH_HOST_SPEEDUP = 3'h3,
      DSH_HOST_LISTEN  = 3'h2,
      DSH_HOST_MEASURE = 3'h6
   } dsh_host_state_type;

endpackage

/* shared/dsh_link_if.sv */
// single-wire debug link between device end and probe end
`timescale 1ns/1ps
interface dsh_link_if;
   logic dev_out;
   logic dev_oe;
   logic host_out;
   logic host_oe;
   logic debug_serial_pin;

   // pulled-up wire: any side driving low wins
   assign debug_serial_pin = (dev_oe ? dev_out : 1'b1) & (host_oe ? host_out : 1'b1);

   modport dev (
      input  debug_serial_pin,
      output dev_out,
      output dev_oe
   );
   modport host (
      input  debug_serial_pin,
      output host_out,
      output host_oe
   );
endinterface

/* verilog/dsh_sync2.sv */
// two-stage synchroniser for the debug pin, idles high
`timescale 1ns/1ps
module dsh_sync2 (
   // clock and reset
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   // asynchronous level in, synchronised level out
   input  wire logic d,
   output logic      q
);
   typedef struct packed {
      logic meta;
      logic stable;
   } dsh_sync_type;

   dsh_sync_type r_q;
   dsh_sync_type r_d;

   // first stage feeds only the second
   always_comb begin
      r_d.meta   = d;
      r_d.stable = r_q.meta;
   end

   // pin idles high through the pull-up
   always_ff @(posedge clk) begin
      if (srst) begin
         r_q <= '1;
      end else if (ce) begin
         r_q <= r_d;
      end
   end

   assign q = r_q.stable;
endmodule

/* verilog/dsh_device.sv */
// device end: acknowledge handshake, speed-probe reply and single step
`timescale 1ns/1ps
module dsh_device
   import dsh_pkg::*;
(
   // clock, reset, enable
   input  wire logic            clk,
   input  wire logic            srst,
   input  wire logic            ce,
   // link
   dsh_link_if.dev              link,
   // decoded commands from the serial front end
   input  wire logic            cmd_valid,
   input  dsh_pkg::dsh_cmd_type cmd_kind,
   input  wire logic            bus_done,
   // processor status
   input  wire logic            background_debug_state,
   input  wire logic            irq_pending,
   // status and control out
   output logic                 ack_enabled,
   output logic                 ack_pending,
   output logic                 discard_cmd,
   output logic                 sync_busy,
   output logic                 step_req,
   output logic                 step_irq_only,
   output logic                 force_halt_instruction
);
   import dsh_pkg::*;

   typedef struct packed {
      dsh_dev_state_type st;
      logic [7:0]        cnt;
      logic [7:0]        low_cnt;
      logic [7:0]        gap;
      logic              pin_prev;
      logic              halt_instruction_prev;
      logic              oe;
      logic              out;
      logic              ack_en;
      logic              pend;
      logic              ready;
      dsh_wait_type      wait_on;
      logic              discard;
      logic              step_req;
      logic              step_run;
      logic              irq_only;
      logic              force_halt_instruction;
   } dsh_dev_reg_type;

   dsh_dev_reg_type r_q;
   dsh_dev_reg_type r_d;
   logic            pin_s;
   logic            pin_fall;
   logic            halt_instruction_rise;
   logic            halt_instruction_fall;
   logic            met;

   // ---------------------------------------------------------------------
   // pin input
   // ---------------------------------------------------------------------
   dsh_sync2 u_pin_sync (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .d    (link.debug_serial_pin),
      .q    (pin_s)
   );

   // ---------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------
   // edges seen by the pin and processor status
   always_comb begin
      pin_fall  = r_q.pin_prev & ~pin_s;
      halt_instruction_rise = background_debug_state & ~r_q.halt_instruction_prev;
      halt_instruction_fall = ~background_debug_state & r_q.halt_instruction_prev;
      case (r_q.wait_on)
         DSH_WAIT_BUS:   met = bus_done;
         DSH_WAIT_ENTER: met = halt_instruction_rise;
         DSH_WAIT_EXIT:  met = halt_instruction_fall;
         default:        met = 1'b1;
      endcase
   end

   // command bookkeeping, step control and pin sequencer
   always_comb begin
      r_d           = r_q;
      r_d.discard   = 1'b0;
      r_d.step_req  = 1'b0;
      r_d.pin_prev  = pin_s;
      r_d.halt_instruction_prev = background_debug_state;
      if (r_q.gap != 8'h00) begin
         r_d.gap = r_q.gap - 8'h01;
      end
      // a new command or the speedup cycle below clears it; otherwise the release event is latched even if it races the launch
      if (r_q.pend && met) begin
         r_d.ready = 1'b1;
      end

      // step: one instruction out, then back to background
      if (r_q.step_run && halt_instruction_fall) begin
         r_d.force_halt_instruction = 1'b1;
      end
      if (r_q.step_run && halt_instruction_rise) begin
         r_d.force_halt_instruction = 1'b0;
         r_d.step_run   = 1'b0;
      end

      if (cmd_valid) begin
         r_d.gap     = DSH_ACK_GAP_CYC;
         r_d.ready   = 1'b0;
         r_d.pend    = r_q.ack_en;
         r_d.wait_on = DSH_WAIT_NOW;
         case (cmd_kind)
            DSH_CMD_ACK_ON: begin
               r_d.ack_en = 1'b1;
               r_d.pend   = 1'b1;
            end
            DSH_CMD_ACK_OFF: begin
               r_d.ack_en = 1'b0;
               r_d.pend   = 1'b0;
            end
            DSH_CMD_READ, DSH_CMD_WRITE: begin
               r_d.wait_on = DSH_WAIT_BUS;
            end
            DSH_CMD_HALT, DSH_CMD_RESUME_UNTIL: begin
               r_d.wait_on = DSH_WAIT_ENTER;
            end
            DSH_CMD_RESUME: begin
               r_d.wait_on = DSH_WAIT_EXIT;
            end
            DSH_CMD_STEP: begin
               r_d.wait_on = DSH_WAIT_ENTER;
               if (background_debug_state) begin
                  r_d.step_req = 1'b1;
                  r_d.step_run = 1'b1;
                  r_d.irq_only = irq_pending;
               end
            end
            DSH_CMD_RESUME_TAGS: begin
               r_d.pend = 1'b0;
            end
            default: begin
               r_d.pend = 1'b0;
            end
         endcase
      end

      case (r_q.st)
         DSH_DEV_IDLE: begin
            // any fall from here opens a new frame
            r_d.oe      = 1'b0;
            r_d.low_cnt = pin_s ? 8'h00 : r_q.low_cnt + 8'h01;
            // a command taken on the same edge is newer than the abort
            if (pin_fall && !cmd_valid) begin
               r_d.pend = 1'b0;
            end
            if (!pin_s && r_q.low_cnt == DSH_SYNC_DETECT_CYC - 8'h01) begin
               r_d.st      = DSH_DEV_SYNC_WAIT;
               r_d.discard = 1'b1;
               r_d.pend    = 1'b0;
               r_d.low_cnt = 8'h00;
            end else if (r_q.pend && (r_q.ready || met) && r_q.gap == 8'h00 && pin_s && !cmd_valid) begin
               r_d.st  = DSH_DEV_ACK_LOW;
               r_d.oe  = 1'b1;
               r_d.out = 1'b0;
               r_d.cnt = DSH_ACK_LOW_CYC - 8'h01;
            end
         end
         DSH_DEV_ACK_LOW: begin
            if (r_q.cnt == 8'h00) begin
               r_d.st  = DSH_DEV_ACK_HIGH;
               r_d.out = 1'b1;
            end else begin
               r_d.cnt = r_q.cnt - 8'h01;
            end
         end
         DSH_DEV_ACK_HIGH: begin
            r_d.st    = DSH_DEV_IDLE;
            r_d.oe    = 1'b0;
            // a command landing on the last cycle rearms instead of being lost
            if (!cmd_valid) begin
               r_d.pend  = 1'b0;
               r_d.ready = 1'b0;
            end
         end
         DSH_DEV_SYNC_WAIT: begin
            // no timeout: a pin stuck low holds us here
            if (pin_s) begin
               r_d.st  = DSH_DEV_SYNC_DLY;
               r_d.cnt = DSH_SYNC_DELAY_CYC - 8'h01;
            end
         end
         DSH_DEV_SYNC_DLY: begin
            if (r_q.cnt == 8'h00) begin
               r_d.st  = DSH_DEV_SYNC_LOW;
               r_d.oe  = 1'b1;
               r_d.out = 1'b0;
               r_d.cnt = DSH_SYNC_LOW_CYC - 8'h01;
            end else begin
               r_d.cnt = r_q.cnt - 8'h01;
            end
         end
         DSH_DEV_SYNC_LOW: begin
            if (r_q.cnt == 8'h00) begin
               r_d.st  = DSH_DEV_SYNC_HIGH;
               r_d.out = 1'b1;
            end else begin
               r_d.cnt = r_q.cnt - 8'h01;
            end
         end
         DSH_DEV_SYNC_HIGH: begin
            r_d.st = DSH_DEV_IDLE;
            r_d.oe = 1'b0;
         end
         default: begin
            r_d.st = DSH_DEV_IDLE;
            r_d.oe = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------------
   // reset clears the enable, so no acknowledge until switched on
   always_ff @(posedge clk) begin
      if (srst) begin
         r_q          <= '0;
         r_q.pin_prev <= 1'b1;
      end else if (ce) begin
         r_q <= r_d;
      end
   end

   // ---------------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------------
   assign link.dev_out  = r_q.out;
   assign link.dev_oe   = r_q.oe;
   assign ack_enabled   = r_q.ack_en;
   assign ack_pending   = r_q.pend;
   assign discard_cmd   = r_q.discard;
   assign sync_busy     = (r_q.st != DSH_DEV_IDLE) && (r_q.st != DSH_DEV_ACK_LOW) && (r_q.st != DSH_DEV_ACK_HIGH);
   assign step_req      = r_q.step_req;
   assign step_irq_only = r_q.irq_only;
   assign force_halt_instruction    = r_q.force_halt_instruction;
endmodule

/* verilog/dsh_host.sv */
// probe end: speed probe, reply timing and acknowledge or worst-case pacing
`timescale 1ns/1ps
module dsh_host
   import dsh_pkg::*;
(
   // clock, reset, enable
   input  wire logic  clk,
   input  wire logic  srst,
   input  wire logic  ce,
   // link
   dsh_link_if.host   link,
   // user requests
   input  wire logic  sync_req,
   input  wire logic  cmd_sent,
   input  wire logic  hs_enabled,
   // results
   output logic       sync_busy,
   output logic       speed_valid,
   output logic [9:0] speed_cycles,
   output logic       ack_seen,
   output logic       proceed
);
   import dsh_pkg::*;

   typedef struct packed {
      dsh_host_state_type st;
      logic [9:0]         cnt;
      logic [9:0]         low_cnt;
      logic [15:0]        wcnt;
      logic               waiting;
      logic               pin_prev;
      logic               oe;
      logic               out;
      logic [9:0]         speed;
      logic               speed_valid;
      logic               ack_seen;
      logic               proceed;
   } dsh_host_reg_type;

   dsh_host_reg_type r_q;
   dsh_host_reg_type r_d;
   logic             pin_s;
   logic             ack_now;

   dsh_sync2 u_pin_sync (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .d    (link.debug_serial_pin),
      .q    (pin_s)
   );

   // ---------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------
   // a short low pulse ending while idle is taken as an acknowledge
   always_comb begin
      ack_now = (r_q.st == DSH_HOST_IDLE) && pin_s && !r_q.pin_prev &&
                r_q.low_cnt >= DSH_HOST_ACK_MIN_CYC && r_q.low_cnt <= DSH_HOST_ACK_MAX_CYC;
   end

   always_comb begin
      r_d             = r_q;
      r_d.pin_prev    = pin_s;
      r_d.speed_valid = 1'b0;
      r_d.ack_seen    = ack_now;
      r_d.proceed     = 1'b0;
      r_d.low_cnt     = pin_s ? 10'h000 : r_q.low_cnt + {9'h000, r_q.low_cnt != 10'h3FF};

      // pacing of the next protocol step
      if (r_q.waiting) begin
         if (hs_enabled && ack_now) begin
            r_d.waiting = 1'b0;
            r_d.proceed = 1'b1;
         end else if (!hs_enabled) begin
            if (r_q.wcnt == 16'h0000) begin
               r_d.waiting = 1'b0;
               r_d.proceed = 1'b1;
            end else begin
               r_d.wcnt = r_q.wcnt - 16'h0001;
            end
         end
      end
      if (cmd_sent) begin
         r_d.waiting = 1'b1;
         r_d.wcnt    = DSH_HOST_WORST_CYC;
      end

      case (r_q.st)
         DSH_HOST_IDLE: begin
            if (sync_req) begin
               r_d.st      = DSH_HOST_REQ_LOW;
               r_d.oe      = 1'b1;
               r_d.out     = 1'b0;
               r_d.cnt     = DSH_HOST_REQ_LOW_CYC - 10'h001;
               r_d.waiting = 1'b0;
            end
         end
         DSH_HOST_REQ_LOW: begin
            if (r_q.cnt == 10'h000) begin
               r_d.st  = DSH_HOST_SPEEDUP;
               r_d.out = 1'b1;
            end else begin
               r_d.cnt = r_q.cnt - 10'h001;
            end
         end
         DSH_HOST_SPEEDUP: begin
            r_d.st = DSH_HOST_LISTEN;
            r_d.oe = 1'b0;
         end
         DSH_HOST_LISTEN: begin
            // our own low still drains out of the synchroniser; wait for a fall
            if (r_q.pin_prev && !pin_s) begin
               r_d.st  = DSH_HOST_MEASURE;
               r_d.cnt = 10'h001;
            end
         end
         DSH_HOST_MEASURE: begin
            if (pin_s) begin
               r_d.st          = DSH_HOST_IDLE;
               r_d.speed       = r_q.cnt;
               r_d.speed_valid = 1'b1;
            end else if (r_q.cnt != 10'h3FF) begin
               r_d.cnt = r_q.cnt + 10'h001;
            end
         end
         default: begin
            r_d.st = DSH_HOST_IDLE;
            r_d.oe = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         r_q          <= '0;
         r_q.pin_prev <= 1'b1;
      end else if (ce) begin
         r_q <= r_d;
      end
   end

   assign link.host_out = r_q.out;
   assign link.host_oe  = r_q.oe;
   assign sync_busy     = r_q.st != DSH_HOST_IDLE;
   assign speed_valid   = r_q.speed_valid;
   assign speed_cycles  = r_q.speed;
   assign ack_seen      = r_q.ack_seen;
   assign proceed       = r_q.proceed;
endmodule

/* sim/dsh_asserts.sv */
// concurrent checks on the single-wire debug link
`timescale 1ns/1ps
module dsh_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link wires
   input wire logic dev_out,
   input wire logic dev_oe,
   input wire logic host_out,
   input wire logic host_oe,
   input wire logic debug_serial_pin
);
   // --------------------------------------------------------
   // helper counters
   // --------------------------------------------------------
   logic [9:0] dlow_q;
   logic [9:0] hlow_q;
   logic [9:0] plow_q;
   logic       rst_q;

   // low-time counters; rst_q masks the edge after reset, where $past sees pre-reset drive
   always_ff @(posedge clk) begin
      rst_q <= srst;
      if (srst) begin
         dlow_q <= 10'h000;
         hlow_q <= 10'h000;
         plow_q <= 10'h000;
      end else begin
         dlow_q <= (dev_oe && !dev_out) ? dlow_q + 10'h001 : 10'h000;
         hlow_q <= (host_oe && !host_out) ? hlow_q + 10'h001 : 10'h000;
         plow_q <= !debug_serial_pin ? plow_q + 10'h001 : 10'h000;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst || rst_q);

   a_pulse_low_len: assert property (dev_oe && dev_out |-> dlow_q == 10'h010 || dlow_q == 10'h080)
      else $error("device low drive of wrong length");
   a_start_low: assert property ($rose(dev_oe) |-> !dev_out)
      else $error("device drive did not start low");
   a_speedup_one: assert property (dev_oe && dev_out |=> !dev_oe)
      else $error("device speedup longer than one cycle");
   a_release_high: assert property ($fell(dev_oe) |-> $past(dev_out))
      else $error("device released without speedup");
   a_launch_pin_high: assert property ($rose(dev_oe) |-> $past(debug_serial_pin, 3) && $past(debug_serial_pin, 4))
      else $error("device drove while pin was low");
   a_reply_delay: assert property ($rose(debug_serial_pin) && !dev_oe && plow_q >= 10'h080 |->
      (!dev_oe throughout (##16 1'b1)) ##[1:4] dev_oe)
      else $error("probe reply not after the 16 cycle delay");
   a_quiet_after: assert property ($fell(dev_oe) |-> !dev_oe [*8])
      else $error("device drove again right after release");
   a_host_req_len: assert property (host_oe && host_out |-> hlow_q >= 10'h080)
      else $error("probe request low too short");
   a_host_release: assert property (host_oe && host_out |=> !host_oe)
      else $error("probe end kept driving after speedup");
endmodule

/* sim/tb.sv */
// self-checking bench joining device end and probe end
`timescale 1ns/1ps
module tb;
   import dsh_pkg::*;
   // --------------------------------------------------------
   // stimulus, model state and instances
   // --------------------------------------------------------
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        cmd_valid = 1'b0;
   dsh_cmd_type cmd_kind = DSH_CMD_OTHER;
   logic        bus_done = 1'b0;
   logic        bg = 1'b0;
   logic        irq = 1'b0;
   logic        sync_req = 1'b0;
   logic        cmd_sent = 1'b0;
   logic        hs_en = 1'b0;
   logic        ack_enabled, ack_pending, discard_cmd, step_req, step_irq_only, force_halt_instruction;
   logic        speed_valid, ack_seen, proceed;
   logic        dev_busy, host_busy;
   logic [9:0]  speed_cycles;
   int          miscompares = 0;
   int          n_checks = 0;
   int          en_m = 0;
   dsh_cmd_type ks[10] = '{DSH_CMD_ACK_ON, DSH_CMD_READ, DSH_CMD_WRITE, DSH_CMD_HALT, DSH_CMD_STEP,
                           DSH_CMD_RESUME, DSH_CMD_RESUME_UNTIL, DSH_CMD_RESUME_TAGS, DSH_CMD_OTHER, DSH_CMD_ACK_OFF};
   int          evs[10] = '{0, 1, 1, 2, 4, 3, 2, 3, 0, 0};

   // 125 MHz clock
   always #4 clk = ~clk;

   dsh_link_if link ();
   dsh_device dsh_device_i (.clk(clk), .srst(srst), .ce(1'b1), .link(link.dev), .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind), .bus_done(bus_done), .background_debug_state(bg), .irq_pending(irq),
      .ack_enabled(ack_enabled), .ack_pending(ack_pending), .discard_cmd(discard_cmd), .sync_busy(dev_busy),
      .step_req(step_req), .step_irq_only(step_irq_only), .force_halt_instruction(force_halt_instruction));
   dsh_host dsh_host_i (.clk(clk), .srst(srst), .ce(1'b1), .link(link.host), .sync_req(sync_req),
      .cmd_sent(cmd_sent), .hs_enabled(hs_en), .sync_busy(host_busy), .speed_valid(speed_valid),
      .speed_cycles(speed_cycles), .ack_seen(ack_seen), .proceed(proceed));
   dsh_asserts dsh_asserts_i (.clk(clk), .srst(srst), .dev_out(link.dev_out), .dev_oe(link.dev_oe),
      .host_out(link.host_out), .host_oe(link.host_oe), .debug_serial_pin(link.debug_serial_pin));

   // flag comparison
   task automatic chk_bit(string what, logic exp, logic got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // count comparison
   task automatic chk_num(string what, logic [9:0] exp, logic [9:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask

   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one command, its release event, and the model's verdict on the acknowledge
   task automatic do_cmd(dsh_cmd_type k, int ev);
      int   d, t_rise, low, st, fc, pr, as, lim, rel;
      logic ack_m;
      ack_m = (k == DSH_CMD_ACK_ON) || (en_m != 0 && k inside {DSH_CMD_READ, DSH_CMD_WRITE, DSH_CMD_HALT,
              DSH_CMD_RESUME, DSH_CMD_RESUME_UNTIL, DSH_CMD_STEP});
      if (k == DSH_CMD_ACK_ON) en_m = 1;
      if (k == DSH_CMD_ACK_OFF) en_m = 0;
      lim = (en_m != 0) ? 200 : 1100; // pacing without handshake takes 1025 cycles
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_kind = k;
      irq = 1'($urandom_range(1, 0));
      hs_en = 1'(en_m);
      cmd_sent = ack_m || en_m == 0;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_sent = 1'b0;
      d = $urandom_range(40, 2);
      // the step pulse stands only in the cycle right after the command
      t_rise = 0; low = 0; st = int'(step_req === 1'b1); fc = 0; pr = 0; as = 0;
      for (int c = 1; c <= lim; c++) begin
         @(negedge clk);
         if (link.dev_oe === 1'b1 && t_rise == 0) t_rise = c;
         low += (link.dev_oe === 1'b1 && link.dev_out === 1'b0);
         st += (step_req === 1'b1);
         fc += (force_halt_instruction === 1'b1);
         pr += (proceed === 1'b1);
         as += (ack_seen === 1'b1);
         bus_done = (c == d && ev == 1);
         if ((c == d && ev == 2) || (c == d + 5 && ev == 4)) bg = 1'b1;
         if (c == d && ev >= 3) bg = 1'b0;
      end
      // release seen one edge after it is driven, never before the 32-cycle gap
      rel = (ev == 0) ? 0 : d + ((ev == 4) ? 6 : 1);
      rel = (rel > int'(DSH_ACK_GAP_CYC)) ? rel : int'(DSH_ACK_GAP_CYC) + 1;
      chk_bit("ack issued", ack_m, t_rise > 0);
      if (t_rise > 0) begin
         chk_num("ack low cycles", 10'h010, 10'(low));
         chk_num("ack launch cycle", 10'(rel), 10'(t_rise));
      end
      if (k == DSH_CMD_ACK_ON) chk_num("ack delay", 10'h021, 10'(t_rise));
      chk_num("ack seen", 10'(ack_m), 10'(as));
      chk_num("proceed", 10'(ack_m || en_m == 0), 10'(pr));
      chk_bit("ack enabled", 1'(en_m), ack_enabled);
      if (k == DSH_CMD_STEP) begin
         chk_num("step pulses", 10'h001, 10'(st));
         chk_bit("step irq only", irq, step_irq_only);
         chk_bit("forced back", 1'b1, fc > 0);
      end
      $display("test %s done", k.name());
   endtask

   // speed probe aborting a pending read acknowledge
   task automatic do_sync();
      int         dc, rises, sv, db, hb;
      logic       prev;
      logic [9:0] spd;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_kind = DSH_CMD_READ;
      @(negedge clk);
      cmd_valid = 1'b0;
      repeat (40) @(negedge clk);
      chk_bit("pending", 1'b1, ack_pending);
      sync_req = 1'b1;
      @(negedge clk);
      sync_req = 1'b0;
      dc = 0; rises = 0; sv = 0; prev = 1'b0; spd = 10'h000; db = 0; hb = 0;
      for (int c = 0; c < 900; c++) begin
         @(negedge clk);
         dc += (discard_cmd === 1'b1);
         db += (dev_busy === 1'b1);
         hb += (host_busy === 1'b1);
         rises += (link.dev_oe === 1'b1 && prev !== 1'b1);
         prev = link.dev_oe;
         if (speed_valid === 1'b1) begin
            sv++;
            spd = speed_cycles;
         end
         bus_done = (c == 300); // late completion must stay silent
      end
      chk_num("discard pulses", 10'h001, 10'(dc));
      chk_num("device drives", 10'h001, 10'(rises));
      chk_num("speed results", 10'h001, 10'(sv));
      chk_num("speed cycles", 10'h080, spd);
      chk_bit("pending after probe", 1'b0, ack_pending);
      // wait for high, 16 delay, 128 low, 1 speedup
      chk_num("reply busy cycles", 10'(DSH_HOST_REQ_LOW_CYC) - 10'(DSH_SYNC_DETECT_CYC) + 10'(DSH_SYNC_DELAY_CYC)
              + 10'(DSH_SYNC_LOW_CYC) + 10'h002, 10'(db));
      chk_bit("probe busy", 1'b1, hb > int'(DSH_HOST_REQ_LOW_CYC));
      chk_bit("reply idle", 1'b0, dev_busy);
      chk_bit("probe idle", 1'b0, host_busy);
      $display("test sync done");
   endtask

   // main sequence
   initial begin
      void'($urandom(87711));
      repeat (2) @(negedge clk);
      srst = 1'b0;
      chk_bit("enabled after reset", 1'b0, ack_enabled);
      do_cmd(DSH_CMD_READ, 1);
      for (int i = 0; i < 10; i++) begin
         do_cmd(ks[i], evs[i]);
      end
      do_cmd(DSH_CMD_ACK_ON, 0);
      do_sync();
      do_cmd(DSH_CMD_ACK_ON, 0);
      @(negedge clk);
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      en_m = 0;
      chk_bit("enabled after reset", 1'b0, ack_enabled);
      do_cmd(DSH_CMD_READ, 1);
      end_of_test();
   end

   // hang guard, well beyond the longest sequence
   initial begin
      #400000;
      miscompares++;
      end_of_test();
   end
endmodule
